// ==== sccc_pkg.sv ====
// Purpose: Shared constants for the system and module clock control block
// Assumes: APB register word per index, byte address is four times the index
// Notes: Clock sources are modelled as pclk-synchronous levels and edge strobes
package sccc_pkg;
	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [7:0] SCCC_IDX_MCE0 = 8'h63;
	localparam logic [7:0] SCCC_IDX_MCE1 = 8'h64;
	localparam logic [7:0] SCCC_IDX_MCE2 = 8'h65;
	localparam logic [7:0] SCCC_IDX_SYSSEL = 8'h66;
	localparam logic [7:0] SCCC_IDX_I2S_STEP = 8'h67;
	localparam logic [7:0] SCCC_IDX_I2S_MOD = 8'h68;
	localparam logic [7:0] SCCC_IDX_CODEC_DIVIDER_INCREMENT = 8'h6C;
	localparam logic [7:0] SCCC_IDX_CODEC_DIVIDER_MODULUS = 8'h6D;
	localparam logic [7:0] SCCC_IDX_HSSEL = 8'h70;
	localparam int SCCC_ADDR_LSB = 2;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SCCC_RST_MCE0 = 8'h83;
	localparam logic [7:0] SCCC_RST_MCE1 = 8'h00;
	localparam logic [7:0] SCCC_RST_MCE2 = 8'h30;
	localparam logic [7:0] SCCC_RST_SYSSEL = 8'h06;
	localparam logic [7:0] SCCC_RST_I2S_STEP = 8'h00;
	localparam logic [7:0] SCCC_RST_I2S_MOD = 8'h02;
	localparam logic [7:0] SCCC_RST_CODEC_DIVIDER_INCREMENT = 8'h01;
	localparam logic [7:0] SCCC_RST_CODEC_DIVIDER_MODULUS = 8'h02;
	localparam logic [7:0] SCCC_RST_HSSEL = 8'h00;
	// ------------------------------------------------------------
	// Writable bit masks, reserved bits read zero
	// ------------------------------------------------------------
	localparam logic [7:0] SCCC_MASK_MCE1 = 8'h9F;
	localparam logic [7:0] SCCC_MASK_MCE2 = 8'h3F;
	localparam logic [7:0] SCCC_MASK_HSSEL = 8'h01;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SCCC_DIV_MSB = 4;
	localparam int SCCC_SRC_MSB = 6;
	localparam int SCCC_SRC_LSB = 5;
	localparam int SCCC_FHS_LO_BIT = 7;
	localparam int SCCC_FHS_HI_BIT = 0;
	localparam int SCCC_DIVEN_BIT = 7;
	localparam int SCCC_STEP_MSB = 6;
	localparam int SCCC_USB_EN_BIT = 3;
	localparam int SCCC_STIMER_EN_BIT = 1;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SCCC_SRC_RC = 2'h0;
	localparam logic [1:0] SCCC_SRC_FHS = 2'h1;
	localparam logic [1:0] SCCC_SRC_HSDIV = 2'h2;
	localparam logic [1:0] SCCC_SRC_32M = 2'h3;
	localparam logic [1:0] SCCC_FHS_48M = 2'h0;
	localparam logic [1:0] SCCC_FHS_RC = 2'h1;
	// Two of every three input edges are passed by a 2/3 divider
	localparam logic [1:0] SCCC_DIV23_DROP = 2'h2;
	typedef enum logic [1:0] {
		SCCC_SW_RUN = 2'b00,
		SCCC_SW_WAIT = 2'b01
	} sccc_sw_state_t;
endpackage

// ==== sccc_frac_div.sv ====
// Purpose: Step/mod fractional divider on the 48 MHz edge strobe
// Assumes: Software keeps mod at least twice step
// Notes: Output level toggles at most once per input strobe
`timescale 1ns/1ps
`default_nettype none
module sccc_frac_div #(
	parameter int STEP_W = 7,
	parameter int MOD_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_48m,
	input wire logic enable,
	input wire logic [STEP_W-1:0] step,
	input wire logic [MOD_W-1:0] modulus,
	output logic clk_level,
	output logic clk_tick
);
	localparam int ACC_W = MOD_W + 1;
	initial begin
		if (STEP_W + 1 > MOD_W) begin
			$error("sccc_frac_div: step field too wide for modulus");
		end
	end
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] sum;
	logic wrap;
	// ------------------------------------------------------------
	// Phase accumulator, doubled step gives two toggles per period
	// ------------------------------------------------------------
	assign sum = acc_q + ACC_W'({step, 1'b0});
	assign wrap = (sum >= ACC_W'(modulus));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= '0;
		end else if (!enable) begin
			acc_q <= '0;
		end else if (tick_48m) begin
			acc_q <= wrap ? ACC_W'(sum - ACC_W'(modulus)) : sum;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_level <= 1'b0;
		end else if (!enable) begin
			clk_level <= 1'b0;
		end else if (tick_48m && wrap) begin
			clk_level <= ~clk_level;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_tick <= 1'b0;
		end else begin
			clk_tick <= enable && tick_48m && wrap && !clk_level;
		end
	end
endmodule
`default_nettype wire

// ==== sccc_clock_ctrl.sv ====
// Purpose: System clock selection, module clock gating, audio clock dividers
// Assumes: Oscillator inputs are pclk-synchronous levels, far slower than pclk
// Notes: Derived clocks leave as one-cycle strobes per rising edge, except i2s_clock and codec_clock, which leave as levels
`timescale 1ns/1ps
`default_nettype none
module sccc_clock_ctrl
	import sccc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int DIV_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rc_osc_24m_clock,
	input wire logic crystal_clock_a,
	output logic sys_clock_tick,
	output logic high_speed_clock,
	output logic stimer_clock_tick,
	output logic usb_clock_tick,
	output logic i2s_clock,
	output logic codec_clock,
	output logic [23:0] module_clock_tick,
	output logic [1:0] sys_src_active
);
	initial begin
		if (ADDR_W < SCCC_ADDR_LSB + 9 || DIV_W != SCCC_DIV_MSB + 1) begin
			$error("sccc_clock_ctrl: unsupported parameter values");
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic rise(input logic prev, input logic cur);
		return cur && !prev;
	endfunction
	function automatic logic [1:0] mod3_next(input logic [1:0] cnt);
		return (cnt == SCCC_DIV23_DROP) ? 2'h0 : 2'(cnt + 2'h1);
	endfunction
	function automatic logic sel_tick(input logic [1:0] sel, input logic [3:0] ticks);
		return ticks[sel];
	endfunction
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] mce0_q;
	logic [7:0] mce1_q;
	logic [7:0] mce2_q;
	logic [7:0] syssel_q;
	logic [7:0] i2s_step_q;
	logic [7:0] i2s_mod_q;
	logic [7:0] codec_divider_increment_q;
	logic [7:0] codec_divider_modulus_q;
	logic [7:0] hssel_q;
	logic [7:0] word_idx;
	logic idx_hit;
	logic access;
	logic wr_en;
	logic [7:0] rd_byte;
	assign word_idx = paddr[SCCC_ADDR_LSB +: 8];
	assign access = psel && penable && pready;
	assign wr_en = access && pwrite && idx_hit;
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	always_comb begin
		idx_hit = 1'b1;
		rd_byte = 8'h00;
		if (paddr[SCCC_ADDR_LSB-1:0] != '0 || paddr[ADDR_W-1:SCCC_ADDR_LSB+8] != '0) begin
			idx_hit = 1'b0;
		end else begin
			unique case (word_idx)
				SCCC_IDX_MCE0: rd_byte = mce0_q;
				SCCC_IDX_MCE1: rd_byte = mce1_q;
				SCCC_IDX_MCE2: rd_byte = mce2_q;
				SCCC_IDX_SYSSEL: rd_byte = syssel_q;
				SCCC_IDX_I2S_STEP: rd_byte = i2s_step_q;
				SCCC_IDX_I2S_MOD: rd_byte = i2s_mod_q;
				SCCC_IDX_CODEC_DIVIDER_INCREMENT: rd_byte = codec_divider_increment_q;
				SCCC_IDX_CODEC_DIVIDER_MODULUS: rd_byte = codec_divider_modulus_q;
				SCCC_IDX_HSSEL: rd_byte = hssel_q;
				default: idx_hit = 1'b0;
			endcase
		end
	end
	// ------------------------------------------------------------
	// APB handshake, one wait state per transfer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= (!pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr <= !idx_hit;
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mce0_q <= SCCC_RST_MCE0;
			mce1_q <= SCCC_RST_MCE1;
			mce2_q <= SCCC_RST_MCE2;
		end else if (wr_en) begin
			if (word_idx == SCCC_IDX_MCE0) begin
				mce0_q <= pwdata[7:0];
			end
			if (word_idx == SCCC_IDX_MCE1) begin
				mce1_q <= pwdata[7:0] & SCCC_MASK_MCE1;
			end
			if (word_idx == SCCC_IDX_MCE2) begin
				mce2_q <= pwdata[7:0] & SCCC_MASK_MCE2;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syssel_q <= SCCC_RST_SYSSEL;
			hssel_q <= SCCC_RST_HSSEL;
		end else if (wr_en) begin
			if (word_idx == SCCC_IDX_SYSSEL) begin
				syssel_q <= pwdata[7:0];
			end
			if (word_idx == SCCC_IDX_HSSEL) begin
				hssel_q <= pwdata[7:0] & SCCC_MASK_HSSEL;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i2s_step_q <= SCCC_RST_I2S_STEP;
			i2s_mod_q <= SCCC_RST_I2S_MOD;
			codec_divider_increment_q <= SCCC_RST_CODEC_DIVIDER_INCREMENT;
			codec_divider_modulus_q <= SCCC_RST_CODEC_DIVIDER_MODULUS;
		end else if (wr_en) begin
			if (word_idx == SCCC_IDX_I2S_STEP) begin
				i2s_step_q <= pwdata[7:0];
			end
			if (word_idx == SCCC_IDX_I2S_MOD) begin
				i2s_mod_q <= pwdata[7:0];
			end
			if (word_idx == SCCC_IDX_CODEC_DIVIDER_INCREMENT) begin
				codec_divider_increment_q <= pwdata[7:0];
			end
			if (word_idx == SCCC_IDX_CODEC_DIVIDER_MODULUS) begin
				codec_divider_modulus_q <= pwdata[7:0];
			end
		end
	end
	// ------------------------------------------------------------
	// Source edge detection and derived strobes
	// ------------------------------------------------------------
	logic rc_prev_q;
	logic xtal_prev_q;
	logic rc_tick;
	logic xtal_tick;
	logic tick_48m;
	logic [1:0] cnt32_q;
	logic [1:0] cnt16_q;
	logic tick_32m;
	logic tick_16m;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_prev_q <= 1'b0;
			xtal_prev_q <= 1'b0;
		end else begin
			rc_prev_q <= rc_osc_24m_clock;
			xtal_prev_q <= crystal_clock_a;
		end
	end
	assign rc_tick = rise(rc_prev_q, rc_osc_24m_clock);
	assign xtal_tick = rise(xtal_prev_q, crystal_clock_a);
	assign tick_48m = crystal_clock_a ^ xtal_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt32_q <= 2'h0;
			cnt16_q <= 2'h0;
		end else begin
			if (tick_48m) begin
				cnt32_q <= mod3_next(cnt32_q);
			end
			if (xtal_tick) begin
				cnt16_q <= mod3_next(cnt16_q);
			end
		end
	end
	assign tick_32m = tick_48m && (cnt32_q != SCCC_DIV23_DROP);
	assign tick_16m = xtal_tick && (cnt16_q != SCCC_DIV23_DROP);
	// ------------------------------------------------------------
	// High-speed clock and its divider
	// ------------------------------------------------------------
	logic [1:0] fhs_code;
	logic fhs_tick;
	logic [DIV_W-1:0] div_val;
	logic [DIV_W-1:0] div_cnt_q;
	logic hsdiv_tick;
	assign fhs_code = {hssel_q[SCCC_FHS_HI_BIT], syssel_q[SCCC_FHS_LO_BIT]};
	always_comb begin
		if (fhs_code[1]) begin
			fhs_tick = xtal_tick;
		end else if (fhs_code == SCCC_FHS_RC) begin
			fhs_tick = rc_tick;
		end else begin
			fhs_tick = tick_48m;
		end
	end
	assign div_val = syssel_q[SCCC_DIV_MSB:0];
	assign hsdiv_tick = fhs_tick && (div_cnt_q >= DIV_W'(div_val - DIV_W'(1)));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= '0;
		end else if (hsdiv_tick) begin
			div_cnt_q <= '0;
		end else if (fhs_tick) begin
			div_cnt_q <= DIV_W'(div_cnt_q + DIV_W'(1));
		end
	end
	// ------------------------------------------------------------
	// Glitch-free system source switch
	// ------------------------------------------------------------
	sccc_sw_state_t sw_state_q;
	logic [1:0] src_req;
	logic [1:0] src_act_q;
	logic [3:0] src_ticks;
	logic cur_tick;
	assign src_req = syssel_q[SCCC_SRC_MSB:SCCC_SRC_LSB];
	assign src_ticks = {tick_32m, hsdiv_tick, fhs_tick, rc_tick};
	assign cur_tick = sel_tick(src_act_q, src_ticks);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state_q <= SCCC_SW_RUN;
			src_act_q <= SCCC_SRC_RC;
		end else begin
			unique case (sw_state_q)
				SCCC_SW_RUN: begin
					if (src_req != src_act_q) begin
						sw_state_q <= SCCC_SW_WAIT;
					end
				end
				SCCC_SW_WAIT: begin
					if (cur_tick) begin
						src_act_q <= src_req;
						sw_state_q <= SCCC_SW_RUN;
					end
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// Registered clock outputs
	// ------------------------------------------------------------
	logic i2s_level;
	logic codec_level;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clock_tick <= 1'b0;
			high_speed_clock <= 1'b0;
			stimer_clock_tick <= 1'b0;
			usb_clock_tick <= 1'b0;
			module_clock_tick <= 24'h00_0000;
			sys_src_active <= SCCC_SRC_RC;
			i2s_clock <= 1'b0;
			codec_clock <= 1'b0;
		end else begin
			sys_clock_tick <= cur_tick;
			high_speed_clock <= fhs_tick;
			stimer_clock_tick <= tick_16m && mce1_q[SCCC_STIMER_EN_BIT];
			usb_clock_tick <= tick_48m && mce0_q[SCCC_USB_EN_BIT];
			module_clock_tick <= {mce2_q, mce1_q, mce0_q} & {24{cur_tick}};
			sys_src_active <= src_act_q;
			i2s_clock <= i2s_level;
			codec_clock <= codec_level;
		end
	end
	// ------------------------------------------------------------
	// Audio clock dividers
	// ------------------------------------------------------------
	sccc_frac_div #(
		.STEP_W(SCCC_STEP_MSB + 1),
		.MOD_W(8)
	) u_i2s_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_48m(tick_48m),
		.enable(i2s_step_q[SCCC_DIVEN_BIT]),
		.step(i2s_step_q[SCCC_STEP_MSB:0]),
		.modulus(i2s_mod_q),
		.clk_level(i2s_level),
		.clk_tick()
	);
	sccc_frac_div #(
		.STEP_W(SCCC_STEP_MSB + 1),
		.MOD_W(8)
	) u_codec_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_48m(tick_48m),
		.enable(codec_divider_increment_q[SCCC_DIVEN_BIT]),
		.step(codec_divider_increment_q[SCCC_STEP_MSB:0]),
		.modulus(codec_divider_modulus_q),
		.clk_level(codec_level),
		.clk_tick()
	);
endmodule
`default_nettype wire

// ==== sccc_clock_ctrl_properties.sv ====
// Purpose: Port-level properties of the clock control block
// Assumes: APB master holds each request until pready
// Notes: Gate and enable copies are rebuilt from observed APB writes
`timescale 1ns/1ps
`default_nettype none
module sccc_clock_ctrl_checker
	import sccc_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int DIV_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rc_osc_24m_clock,
	input wire logic crystal_clock_a,
	input wire logic sys_clock_tick,
	input wire logic high_speed_clock,
	input wire logic stimer_clock_tick,
	input wire logic usb_clock_tick,
	input wire logic i2s_clock,
	input wire logic codec_clock,
	input wire logic [23:0] module_clock_tick,
	input wire logic [1:0] sys_src_active
);
	// ------------------------------------------------------------
	// Register shadows
	// ------------------------------------------------------------
	logic [23:0] gate_q;
	logic i2s_en_q;
	logic codec_en_q;
	logic wr_take;
	logic [2:0] xt_h_q;
	assign wr_take = psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xt_h_q <= 3'h0;
		end else begin
			xt_h_q <= {xt_h_q[1:0], crystal_clock_a};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= {SCCC_RST_MCE2, SCCC_RST_MCE1, SCCC_RST_MCE0};
			i2s_en_q <= SCCC_RST_I2S_STEP[7];
			codec_en_q <= SCCC_RST_CODEC_DIVIDER_INCREMENT[7];
		end else if (wr_take) begin
			case (paddr[9:2])
				SCCC_IDX_MCE0: gate_q[7:0] <= pwdata[7:0];
				SCCC_IDX_MCE1: gate_q[15:8] <= pwdata[7:0] & SCCC_MASK_MCE1;
				SCCC_IDX_MCE2: gate_q[23:16] <= pwdata[7:0] & SCCC_MASK_MCE2;
				SCCC_IDX_I2S_STEP: i2s_en_q <= pwdata[7];
				SCCC_IDX_CODEC_DIVIDER_INCREMENT: codec_en_q <= pwdata[7];
				default: ;
			endcase
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_wait;
		psel && $rose(penable) |-> !pready ##1 pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait state");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
	property p_module_gate;
		(module_clock_tick & ~(gate_q | $past(gate_q) | $past(gate_q, 2))) == 24'h0;
	endproperty
	a_module_gate: assert property (p_module_gate) else $error("gated module clock ran");
	property p_module_sys;
		|module_clock_tick |-> sys_clock_tick || $past(sys_clock_tick);
	endproperty
	a_module_sys: assert property (p_module_sys) else $error("module tick without system tick");
	property p_usb_gate;
		usb_clock_tick |-> gate_q[3] || $past(gate_q[3]) || $past(gate_q[3], 2);
	endproperty
	a_usb_gate: assert property (p_usb_gate) else $error("usb clock ran while gated");
	property p_stimer_gate;
		stimer_clock_tick |-> gate_q[9] || $past(gate_q[9]) || $past(gate_q[9], 2);
	endproperty
	a_stimer_gate: assert property (p_stimer_gate) else $error("timer clock ran while gated");
	property p_usb_source;
		usb_clock_tick |-> (crystal_clock_a != xt_h_q[0]) || (xt_h_q[0] != xt_h_q[1])
			|| (xt_h_q[1] != xt_h_q[2]);
	endproperty
	a_usb_source: assert property (p_usb_source) else $error("usb tick without crystal edge");
	property p_i2s_off;
		(!i2s_en_q) [*3] |-> !i2s_clock;
	endproperty
	a_i2s_off: assert property (p_i2s_off) else $error("i2s clock active while disabled");
	property p_codec_off;
		(!codec_en_q) [*3] |-> !codec_clock;
	endproperty
	a_codec_off: assert property (p_codec_off) else $error("codec clock active while disabled");
	property p_src_switch;
		$changed(sys_src_active) |-> sys_clock_tick || $past(sys_clock_tick);
	endproperty
	a_src_switch: assert property (p_src_switch) else $error("source switched off a clock edge");
endmodule
bind sccc_clock_ctrl sccc_clock_ctrl_checker #(.ADDR_W(ADDR_W), .DIV_W(DIV_W)) u_sccc_clock_ctrl_checker (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.rc_osc_24m_clock, .crystal_clock_a, .sys_clock_tick, .high_speed_clock,
	.stimer_clock_tick, .usb_clock_tick, .i2s_clock, .codec_clock, .module_clock_tick,
	.sys_src_active
);
`default_nettype wire

// ==== sccc_clock_ctrl_test.sv ====
// Purpose: Self-checking bench for the clock control block
// Assumes: Crystal toggles every 3 pclk, RC every 5 pclk
// Notes: Counts are taken over 120-cycle windows with a tolerance of one, twenty for the module tick count
`timescale 1ns/1ps
`default_nettype none
module sccc_clock_ctrl_test;
	import sccc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rc, xt;
	logic sys_t, hs_clk, st_t, usb_t, i2s_c, cod_c;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] mod_t;
	logic [1:0] src_act;
	logic er;
	int error_cnt, comparisons, ph, k, s, u, t, m, i, c, h;
	logic [7:0] idx_t[9] = '{SCCC_IDX_MCE0, SCCC_IDX_MCE1, SCCC_IDX_MCE2, SCCC_IDX_SYSSEL,
		SCCC_IDX_I2S_STEP, SCCC_IDX_I2S_MOD, SCCC_IDX_CODEC_DIVIDER_INCREMENT, SCCC_IDX_CODEC_DIVIDER_MODULUS, SCCC_IDX_HSSEL};
	logic [7:0] rst_t[9] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00};
	logic [7:0] row_sel[7] = '{8'h06, 8'h22, 8'h62, 8'hA2, 8'h22, 8'h44, 8'h5F};
	logic [7:0] row_hs[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	int row_exp[7] = '{12, 40, 27, 12, 20, 10, 1};
	sccc_clock_ctrl u_sccc_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_osc_24m_clock(rc), .crystal_clock_a(xt),
		.sys_clock_tick(sys_t), .high_speed_clock(hs_clk), .stimer_clock_tick(st_t),
		.usb_clock_tick(usb_t), .i2s_clock(i2s_c), .codec_clock(cod_c),
		.module_clock_tick(mod_t), .sys_src_active(src_act));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (presetn) begin
			ph <= ph + 1;
			if (ph % 3 == 2) xt <= !xt;
			if (ph % 5 == 4) rc <= !rc;
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic near(input int got, input int exp, input int tol);
		comparisons++;
		if (got < exp - tol || got > exp + tol) begin
			error_cnt++;
			$display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			$display("[FAIL] %0t bus timeout", $time);
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wreg(input logic [7:0] x, input logic [7:0] d);
		apb(1'b1, {2'b00, x, 2'b00}, d);
	endtask
	task automatic rreg(input logic [7:0] x);
		apb(1'b0, {2'b00, x, 2'b00}, 8'h00);
	endtask
	task automatic measure;
		logic pi, pc;
		{s, u, t, m, i, c, h} = '0;
		repeat (150) @(posedge pclk);
		@(negedge pclk);
		pi = i2s_c;
		pc = cod_c;
		repeat (120) begin
			@(negedge pclk);
			s += int'(sys_t);
			h += int'(hs_clk);
			u += int'(usb_t);
			t += int'(st_t);
			m += $countones(mod_t);
			i += int'(i2s_c !== pi);
			c += int'(cod_c !== pc);
			pi = i2s_c;
			pc = cod_c;
		end
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, rc, xt} = '0;
		paddr = '0;
		pwdata = '0;
		{error_cnt, comparisons, ph} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 9; k++) begin
			rreg(idx_t[k]);
			check(rd, {24'h0, rst_t[k]});
			check({31'h0, er}, 32'h0);
		end
		$display("Test reset values done");
		for (k = 0; k < 7; k++) begin
			wreg(SCCC_IDX_HSSEL, row_hs[k]);
			wreg(SCCC_IDX_SYSSEL, row_sel[k]);
			measure();
			near(s, row_exp[k], 1);
			check({30'h0, src_act}, {30'h0, row_sel[k][6:5]});
		end
		$display("Test source table done");
		wreg(SCCC_IDX_MCE1, 8'hFF);
		wreg(SCCC_IDX_MCE2, 8'hFF);
		wreg(SCCC_IDX_HSSEL, 8'hFF);
		rreg(SCCC_IDX_MCE1);
		check(rd, 32'h9F);
		rreg(SCCC_IDX_MCE2);
		check(rd, 32'h3F);
		rreg(SCCC_IDX_HSSEL);
		check(rd, 32'h01);
		apb(1'b0, 12'h1A4, 8'h00);
		check({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, 12'h18D, 8'h00);
		check({31'h0, er}, 32'h1);
		apb(1'b1, 12'h58C, 8'h00);
		check({31'h0, er}, 32'h1);
		rreg(SCCC_IDX_MCE0);
		check(rd, 32'h83);
		$display("Test reserved and unmapped done");
		wreg(SCCC_IDX_HSSEL, 8'h00);
		wreg(SCCC_IDX_SYSSEL, 8'h06);
		wreg(SCCC_IDX_MCE0, 8'hFF);
		measure();
		near(m, 240, 20);
		near(u, 40, 1);
		near(t, 13, 1);
		near(h, 40, 1);
		wreg(SCCC_IDX_MCE0, 8'h00);
		wreg(SCCC_IDX_MCE1, 8'h00);
		wreg(SCCC_IDX_MCE2, 8'h00);
		measure();
		check(m + u + t, 32'h0);
		$display("Test module gating done");
		wreg(SCCC_IDX_I2S_MOD, 8'h04);
		wreg(SCCC_IDX_I2S_STEP, 8'h81);
		wreg(SCCC_IDX_CODEC_DIVIDER_MODULUS, 8'h08);
		wreg(SCCC_IDX_CODEC_DIVIDER_INCREMENT, 8'h83);
		measure();
		near(i, 20, 1);
		near(c, 30, 1);
		wreg(SCCC_IDX_I2S_STEP, 8'h01);
		wreg(SCCC_IDX_CODEC_DIVIDER_INCREMENT, 8'h03);
		measure();
		check({i2s_c, cod_c, 30'(i + c)}, 32'h0);
		$display("Test audio dividers done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rreg(SCCC_IDX_CODEC_DIVIDER_INCREMENT);
		check(rd, {24'h0, SCCC_RST_CODEC_DIVIDER_INCREMENT});
		rreg(SCCC_IDX_MCE0);
		check(rd, {24'h0, SCCC_RST_MCE0});
		check({30'h0, src_act}, {30'h0, SCCC_SRC_RC});
		$display("Test mid-run reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
